// ---- rtl/sleep_power_reset_control_defines.vh ----
`ifndef SLEEP_POWER_RESET_CONTROL_DEFINES_VH
`define SLEEP_POWER_RESET_CONTROL_DEFINES_VH
`define SLP_IDX_SMC        8'h33
`define SLP_DATA_SMC       8'h53
`define SLP_IDX_SYSCTL     8'h35
`define SLP_IDX_GATE       8'h64
`define SLP_IDX_STATUS     8'h70
`define SLP_IDX_CTRL       8'h71
`define SLP_SMC_MASK       8'h0F
`define SLP_GATE_MASK      8'h1F
`define SLP_SYSCTL_MASK    8'h60
`define SLP_RESET_VAL      8'h00
`define SLP_BIT_SOFF       6
`define SLP_BIT_UNLOCK     5
`define SLP_MODE_IDLE      3'h0
`define SLP_MODE_NOISE     3'h1
`define SLP_MODE_DOWN      3'h2
`define SLP_MODE_SAVE      3'h3
`define SLP_MODE_STANDBY   3'h6
`define SLP_UNLOCK_CYC     3'h4
`define SLP_SOFF_DLY_CYC   3'h3
`define SLP_SOFF_HOLD_CYC  3'h3
`define SLP_STANDBY_WAKE   3'h6
`define SLP_EXT_MIN_NS     2500
`define SLP_CLK_NS         50
`define SLP_EXT_MIN_CYC    ((`SLP_EXT_MIN_NS + `SLP_CLK_NS - 1) / `SLP_CLK_NS)
`define SLP_TOUT_DEFAULT   16'h0040
`endif

// ---- rtl/sleep_power_reset_control.v ----
`timescale 1ns/1ns
`default_nettype none
`include "sleep_power_reset_control_defines.vh"
module sleep_power_reset_control (
    input  wire        CLK,
    input  wire        RST_N,
    input  wire [31:0] S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output reg         S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output reg         S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [31:0] S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output reg         S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY,
    input  wire        SLEEP_INSTR,
    input  wire        WAKE_EVENT,
    input  wire        CRYSTAL_CLOCK,
    input  wire        POWER_ON_LOW,
    input  wire        EXT_RESET_N,
    input  wire        WDT_ENABLED,
    input  wire        WDT_EXPIRED,
    input  wire        BROWNOUT_ENABLED,
    input  wire        BROWNOUT_LOW,
    input  wire        DEBUG_RESET_REG,
    input  wire [3:0]  STARTUP_TIME_FUSE,
    input  wire [3:0]  CLOCK_SOURCE_FUSE,
    output reg         SLEEPING,
    output reg  [2:0]  SLEEP_MODE,
    output reg         CORE_STALL,
    output reg         BROWNOUT_DETECTOR_OFF,
    output reg         DISPLAY_GATE,
    output reg         TIMER16_GATE,
    output reg         SPI_GATE,
    output reg         USART_GATE,
    output reg         ADC_GATE,
    output reg         ADC_MUX_BLOCKED,
    output reg         PORT_RESET,
    output reg         INTERNAL_RESET,
    output reg         FETCH_FROM_VECTOR
);
    reg        rst_s1_r;
    reg        rst_s2_r;
    reg  [7:0] smc_r;
    reg  [7:0] sysctl_r;
    reg  [7:0] gate_r;
    reg  [2:0] unlock_cnt_r;
    reg        soff_pend_r;
    reg  [2:0] soff_cnt_r;
    reg        soff_act_r;
    reg  [2:0] wake_cnt_r;
    reg  [7:0] ext_cnt_r;
    reg        ext_rst_r;
    reg  [15:0] tout_cnt_r;
    reg        aw_hold_r;
    reg        w_hold_r;
    reg  [7:0] aw_idx_r;
    reg  [7:0] wdat_r;
    // Core logic sees reset only through the two-stage release below
    wire       rst_n = rst_s2_r;
    wire       wr_go = aw_hold_r && w_hold_r && !S_AXI_BVALID;
    wire       rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
    wire [7:0] rd_idx = S_AXI_ARADDR[9:2];
    wire       wr_smc = wr_go && aw_idx_r == `SLP_IDX_SMC;
    wire       wr_sys = wr_go && aw_idx_r == `SLP_IDX_SYSCTL;
    wire       wr_gate = wr_go && aw_idx_r == `SLP_IDX_GATE;
    wire       wr_ctrl = wr_go && aw_idx_r == `SLP_IDX_CTRL;
    // Level sources combine immediately; the watchdog term lasts as long as WDT_ENABLED and WDT_EXPIRED both stay high
    wire [4:0] src_vec;
    wire       src_any = |src_vec;
    reg        valid_mode;
    reg        wr_hit;
    reg        rd_hit;
    wire [7:0] status_val = {3'h0,
                             INTERNAL_RESET,
                             soff_act_r,
                             BROWNOUT_DETECTOR_OFF,
                             CORE_STALL,
                             SLEEPING};
    wire [15:0] tout_len = {4'h0, STARTUP_TIME_FUSE, CLOCK_SOURCE_FUSE, 4'h0}
                       + `SLP_TOUT_DEFAULT;
    reg  [7:0] rd_val;

    // One line per source keeps each enable qualifier next to its pin
    assign src_vec[0] = POWER_ON_LOW;
    assign src_vec[1] = ext_rst_r;
    assign src_vec[2] = WDT_ENABLED & WDT_EXPIRED;
    assign src_vec[3] = BROWNOUT_ENABLED & BROWNOUT_LOW;
    assign src_vec[4] = DEBUG_RESET_REG;

    // Reserved codes decode as no sleep, so a stray write cannot halt the core
    always @* begin
        case (smc_r[3:1])
            `SLP_MODE_IDLE,
            `SLP_MODE_NOISE,
            `SLP_MODE_DOWN,
            `SLP_MODE_SAVE,
            `SLP_MODE_STANDBY: valid_mode = 1'b1;
            default:           valid_mode = 1'b0;
        endcase
    end

    // Unmapped indices answer with an error instead of silently aliasing
    always @* begin
        case (aw_idx_r)
            `SLP_IDX_SMC,
            `SLP_IDX_SYSCTL,
            `SLP_IDX_GATE,
            `SLP_IDX_STATUS,
            `SLP_IDX_CTRL: wr_hit = 1'b1;
            default:       wr_hit = 1'b0;
        endcase
    end

    always @* begin
        case (rd_idx)
            `SLP_IDX_SMC,
            `SLP_IDX_SYSCTL,
            `SLP_IDX_GATE,
            `SLP_IDX_STATUS,
            `SLP_IDX_CTRL: rd_hit = 1'b1;
            default:       rd_hit = 1'b0;
        endcase
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    always @* begin
        case (rd_idx)
            `SLP_IDX_SMC:    rd_val = smc_r & `SLP_SMC_MASK;
            `SLP_IDX_SYSCTL: rd_val = sysctl_r;
            `SLP_IDX_GATE:   rd_val = gate_r & `SLP_GATE_MASK;
            `SLP_IDX_STATUS: rd_val = status_val;
            default:         rd_val = 8'h00;
        endcase
    end

    // Bus slave: address and data latched separately, response after both
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b0;
            S_AXI_BRESP   <= 2'h0;
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= 2'h0;
            aw_hold_r     <= 1'b0;
            w_hold_r      <= 1'b0;
            aw_idx_r      <= 8'h00;
            wdat_r        <= 8'h00;
        end else begin
            // Ready lasts one cycle so each beat is taken exactly once
            S_AXI_AWREADY <= !aw_hold_r && !S_AXI_AWREADY && S_AXI_AWVALID;
            S_AXI_WREADY  <= !w_hold_r && !S_AXI_WREADY && S_AXI_WVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold_r <= 1'b1;
                aw_idx_r  <= S_AXI_AWADDR[9:2];
            end
            // Only byte lane 0 is kept; every register is eight bits wide
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold_r <= 1'b1;
                wdat_r   <= S_AXI_WSTRB[0] ? S_AXI_WDATA[7:0] : 8'h00;
            end
            // A new write is held off until its response has been taken
            if (wr_go) begin
                aw_hold_r    <= 1'b0;
                w_hold_r     <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= wr_hit ? 2'h0 : 2'h2;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (rd_go) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= {24'h00_0000, rd_val};
                S_AXI_RRESP  <= rd_hit ? 2'h0 : 2'h2;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // Registers return to initial values while internal reset stands
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            smc_r        <= `SLP_RESET_VAL;
            sysctl_r     <= `SLP_RESET_VAL;
            gate_r       <= `SLP_RESET_VAL;
            unlock_cnt_r <= 3'h0;
            soff_pend_r  <= 1'b0;
            soff_cnt_r   <= 3'h0;
            soff_act_r   <= 1'b0;
        end else if (INTERNAL_RESET) begin
            smc_r        <= `SLP_RESET_VAL;
            sysctl_r     <= `SLP_RESET_VAL;
            gate_r       <= `SLP_RESET_VAL;
            unlock_cnt_r <= 3'h0;
            soff_pend_r  <= 1'b0;
            soff_cnt_r   <= 3'h0;
            soff_act_r   <= 1'b0;
        end else begin
            // Countdown goes first so a fresh timed write in this cycle wins
            if (soff_pend_r || soff_act_r) begin
                if (soff_cnt_r == 3'h1) begin
                    if (soff_pend_r) begin
                        soff_pend_r <= 1'b0;
                        soff_act_r  <= 1'b1;
                        soff_cnt_r  <= `SLP_SOFF_HOLD_CYC;
                    end else begin
                        soff_act_r <= 1'b0;
                        sysctl_r[`SLP_BIT_SOFF] <= 1'b0;
                        soff_cnt_r <= 3'h0;
                    end
                end else begin
                    soff_cnt_r <= soff_cnt_r - 3'h1;
                end
            end
            if (wr_smc)
                smc_r <= wdat_r & `SLP_SMC_MASK;
            if (wr_gate)
                gate_r <= wdat_r & `SLP_GATE_MASK;
            if (unlock_cnt_r != 3'h0)
                unlock_cnt_r <= unlock_cnt_r - 3'h1;
            // Unlock step opens a four-cycle window; other writes are ignored
            if (wr_sys && wdat_r[`SLP_BIT_SOFF] && wdat_r[`SLP_BIT_UNLOCK]) begin
                unlock_cnt_r <= `SLP_UNLOCK_CYC;
                sysctl_r[`SLP_BIT_UNLOCK] <= 1'b1;
            end else if (wr_sys && wdat_r[`SLP_BIT_SOFF]
                         && unlock_cnt_r != 3'h0) begin
                unlock_cnt_r <= 3'h0;
                sysctl_r[`SLP_BIT_UNLOCK] <= 1'b0;
                sysctl_r[`SLP_BIT_SOFF] <= 1'b1;
                soff_pend_r <= 1'b1;
                soff_cnt_r  <= `SLP_SOFF_DLY_CYC;
            end else if (unlock_cnt_r == 3'h1) begin
                // Unlock bit drops by itself when the window closes
                sysctl_r[`SLP_BIT_UNLOCK] <= 1'b0;
            end
        end
    end

    // Sleep entry, wake and standby resume delay
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            SLEEPING              <= 1'b0;
            SLEEP_MODE            <= 3'h0;
            CORE_STALL            <= 1'b0;
            BROWNOUT_DETECTOR_OFF <= 1'b0;
            wake_cnt_r            <= 3'h0;
        end else if (INTERNAL_RESET) begin
            SLEEPING              <= 1'b0;
            CORE_STALL            <= 1'b0;
            BROWNOUT_DETECTOR_OFF <= 1'b0;
            wake_cnt_r            <= 3'h0;
            SLEEP_MODE            <= 3'h0;
        end else begin
            SLEEP_MODE <= smc_r[3:1];
            // Sleep-off state is captured at entry; later changes do not count
            if (!SLEEPING && wake_cnt_r == 3'h0 && SLEEP_INSTR && smc_r[0]
                && valid_mode) begin
                SLEEPING   <= 1'b1;
                CORE_STALL <= 1'b1;
                BROWNOUT_DETECTOR_OFF <= soff_act_r;
            end else if (SLEEPING && WAKE_EVENT) begin
                SLEEPING <= 1'b0;
                BROWNOUT_DETECTOR_OFF <= 1'b0;
                // Without a crystal the core resumes at once
                if (SLEEP_MODE == `SLP_MODE_STANDBY && CRYSTAL_CLOCK) begin
                    wake_cnt_r <= `SLP_STANDBY_WAKE - 3'h1;
                end else begin
                    CORE_STALL <= 1'b0;
                end
            end else if (wake_cnt_r != 3'h0) begin
                wake_cnt_r <= wake_cnt_r - 3'h1;
                if (wake_cnt_r == 3'h1)
                    CORE_STALL <= 1'b0;
            end
        end
    end

    // Gates freeze the peripheral clock; a gated peripheral keeps its state
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            DISPLAY_GATE    <= 1'b0;
            TIMER16_GATE    <= 1'b0;
            SPI_GATE        <= 1'b0;
            USART_GATE      <= 1'b0;
            ADC_GATE        <= 1'b0;
            ADC_MUX_BLOCKED <= 1'b0;
        end else begin
            // Gate outputs lag the register by one edge, which software never sees
            DISPLAY_GATE    <= gate_r[4];
            TIMER16_GATE    <= gate_r[3];
            SPI_GATE        <= gate_r[2];
            USART_GATE      <= gate_r[1];
            ADC_GATE        <= gate_r[0];
            ADC_MUX_BLOCKED <= gate_r[0];
        end
    end

    // Port reset is async on any source; only the external pin needs a clock, to pass its filter
    always @(posedge CLK or posedge src_any) begin
        if (src_any)
            PORT_RESET <= 1'b1;
        // Clears on the first edge after every source has dropped
        else
            PORT_RESET <= 1'b0;
    end

    // Filter length is fixed, and it needs a running clock to count
    // Pin filter: short pulses are not guaranteed to reset
    always @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ext_cnt_r <= 8'h00;
            ext_rst_r <= 1'b0;
        end else if (EXT_RESET_N) begin
            ext_cnt_r <= 8'h00;
            ext_rst_r <= 1'b0;
        end else if (ext_cnt_r >= `SLP_EXT_MIN_CYC) begin
            ext_rst_r <= 1'b1;
        end else begin
            ext_cnt_r <= ext_cnt_r + 8'h01;
        end
    end

    // Fuses are read live and must stay static while reset stretches
    // Stretch internal reset; supply loss restarts the count at once
    always @(posedge CLK or posedge POWER_ON_LOW) begin
        if (POWER_ON_LOW) begin
            tout_cnt_r        <= 16'h0000;
            INTERNAL_RESET    <= 1'b1;
            FETCH_FROM_VECTOR <= 1'b0;
        end else if (src_any) begin
            tout_cnt_r        <= 16'h0000;
            INTERNAL_RESET    <= 1'b1;
            FETCH_FROM_VECTOR <= 1'b0;
        end else if (INTERNAL_RESET) begin
            if (tout_cnt_r >= tout_len) begin
                INTERNAL_RESET    <= 1'b0;
                FETCH_FROM_VECTOR <= 1'b1;
            end else begin
                tout_cnt_r <= tout_cnt_r + 16'h0001;
            end
        end else begin
            FETCH_FROM_VECTOR <= 1'b0;
        end
    end

    wire unused_ok = wr_ctrl;
endmodule // sleep_power_reset_control
`default_nettype wire

// ---- dv/sleep_power_reset_control_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module sprc_checker (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SLEEP_INSTR,
    input wire logic POWER_ON_LOW,
    input wire logic DEBUG_RESET_REG,
    input wire logic SLEEPING,
    input wire logic BROWNOUT_DETECTOR_OFF,
    input wire logic ADC_GATE,
    input wire logic ADC_MUX_BLOCKED,
    input wire logic PORT_RESET,
    input wire logic INTERNAL_RESET,
    input wire logic FETCH_FROM_VECTOR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_bod_in_sleep: assert property (
        BROWNOUT_DETECTOR_OFF |-> SLEEPING) else $error("bod off awake");
    a_sleep_cause: assert property (
        $rose(SLEEPING) |-> $past(SLEEP_INSTR) || $past(SLEEP_INSTR, 2))
        else $error("sleep without instruction");
    a_mux_follows: assert property (
        $rose(ADC_GATE) |-> ##[0:1] ADC_MUX_BLOCKED) else $error("mux free");
    a_port_debug: assert property (
        $rose(DEBUG_RESET_REG) |-> ##[0:1] PORT_RESET) else $error("port");
    a_por_now: assert property (
        POWER_ON_LOW |-> INTERNAL_RESET) else $error("por late");
    a_debug_holds: assert property (
        DEBUG_RESET_REG |=> INTERNAL_RESET) else $error("debug dropped");
    a_reset_stretch: assert property (
        $fell(DEBUG_RESET_REG) |-> INTERNAL_RESET [*8])
        else $error("no stretch");
    a_fetch_after: assert property (
        $fell(INTERNAL_RESET) |-> ##[0:1] FETCH_FROM_VECTOR)
        else $error("no fetch");
    a_fetch_single: assert property (
        FETCH_FROM_VECTOR |=> !FETCH_FROM_VECTOR) else $error("fetch long");
    c_sleep: cover property ($rose(SLEEPING));
    c_bod_off: cover property ($rose(BROWNOUT_DETECTOR_OFF));
    c_fetch: cover property (FETCH_FROM_VECTOR);
endmodule // sprc_checker
bind sleep_power_reset_control sprc_checker chk_u (
    .CLK(CLK), .RST_N(RST_N), .SLEEP_INSTR(SLEEP_INSTR),
    .POWER_ON_LOW(POWER_ON_LOW), .DEBUG_RESET_REG(DEBUG_RESET_REG),
    .SLEEPING(SLEEPING), .BROWNOUT_DETECTOR_OFF(BROWNOUT_DETECTOR_OFF),
    .ADC_GATE(ADC_GATE), .ADC_MUX_BLOCKED(ADC_MUX_BLOCKED),
    .PORT_RESET(PORT_RESET), .INTERNAL_RESET(INTERNAL_RESET),
    .FETCH_FROM_VECTOR(FETCH_FROM_VECTOR)
);
`default_nettype wire

// ---- dv/core_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module core_model (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] wake_dly,
    input  wire logic       sleeping,
    output var  logic       sleep_instr,
    output var  logic       wake
);
    logic [3:0] cnt_r;
    initial begin
        sleep_instr = 1'b0;
        wake = 1'b0;
        cnt_r = 4'h0;
    end
    // Wake is held once due, so a slow wake-up is never missed
    always @(posedge clk) begin
        sleep_instr <= go;
        wake <= sleeping && (cnt_r == wake_dly);
        if (!sleeping)
            cnt_r <= 4'h0;
        else if (cnt_r != wake_dly)
            cnt_r <= cnt_r + 4'h1;
    end
endmodule // core_model
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
    localparam logic [31:0] SMC = 32'h0000_00CC;
    localparam logic [31:0] SYS = 32'h0000_00D4;
    localparam logic [31:0] GATE = 32'h0000_0190;
    localparam logic [31:0] BAD = 32'h0000_03FC;
    logic        clk = 1'b0, rst_n = 1'b0, go = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, q, rdata;
    logic [6:0]  srcs = 7'h40;
    logic [3:0]  wake_dly = 4'h2;
    logic [1:0]  bresp, rresp, resp;
    wire  [4:0]  gates;
    logic [2:0]  smode;
    logic        awready, wready, bvalid, arready, rvalid, sleeping;
    logic        bod_off, mux_blk, port_rst, int_rst, sleep_instr, wake, stall;
    logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h4, 3'h5, 3'h7};
    logic [6:0]  pats [7] = '{7'h01, 7'h06, 7'h18, 7'h20, 7'h40, 7'h04, 7'h10};
    int          fails = 0, tests_run = 0;
    sleep_power_reset_control dut_u (
        .CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .SLEEP_INSTR(sleep_instr),
        .WAKE_EVENT(wake), .CRYSTAL_CLOCK(1'b1),
        .POWER_ON_LOW(srcs[6]), .EXT_RESET_N(!srcs[5]),
        .WDT_ENABLED(srcs[1]), .WDT_EXPIRED(srcs[2]),
        .BROWNOUT_ENABLED(srcs[3]), .BROWNOUT_LOW(srcs[4]),
        .DEBUG_RESET_REG(srcs[0]), .STARTUP_TIME_FUSE(4'h0),
        .CLOCK_SOURCE_FUSE(4'h0), .SLEEPING(sleeping), .SLEEP_MODE(smode),
        .CORE_STALL(stall), .BROWNOUT_DETECTOR_OFF(bod_off),
        .DISPLAY_GATE(gates[4]), .TIMER16_GATE(gates[3]),
        .SPI_GATE(gates[2]), .USART_GATE(gates[1]), .ADC_GATE(gates[0]),
        .ADC_MUX_BLOCKED(mux_blk), .PORT_RESET(port_rst),
        .INTERNAL_RESET(int_rst), .FETCH_FROM_VECTOR()
    );
    core_model core_u (
        .clk(clk), .go(go), .wake_dly(wake_dly), .sleeping(sleeping),
        .sleep_instr(sleep_instr), .wake(wake)
    );
    always #25 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Ready is looked at on the falling edge, so it is the value the
    // following rising edge samples, free of update-order races
    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        int n;
        logic ta, tw, tx, tr;
        n = 0;
        if (w) begin
            awaddr <= a;
            wdata <= {24'h00_0000, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
        end else begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
        end
        do begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tx = arvalid && arready;
            tr = (bready && bvalid) || (rready && rvalid);
            q = rdata;
            resp = w ? bresp : rresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tx) arvalid <= 1'b0;
            n++;
        end while (!tr && n < 100);
        if (!tr) fails++;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h00_0000, e});
    endtask
    task automatic release_chk();
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (int_rst !== 1'b0 && n < 200);
        chk(32'(n >= 64 && n <= 72), 32'h0000_0001);
        @(posedge clk);
    endtask
    task automatic nap(input logic [2:0] m, input logic se,
                       input logic [7:0] s1, input logic [7:0] s2,
                       input logic exp, input logic brownout_detector);
        int n;
        bus(1'b1, SMC, {4'h0, m, se});
        if (s1 != 8'h00) bus(1'b1, SYS, s1);
        if (s2 != 8'h00) bus(1'b1, SYS, s2);
        // Sleep-off turns active only after its delay, so give it an edge
        if (s2 != 8'h00) @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (sleeping !== 1'b1 && n < 8);
        chk(32'(sleeping), 32'(exp));
        if (exp) chk(32'(smode), 32'(m));
        chk(32'(bod_off), 32'(brownout_detector));
        n = 0;
        while (sleeping !== 1'b0 && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk(32'(sleeping), 32'h0000_0000);
        n = 1;
        while (stall === 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(n, (exp && m == 3'h6) ? 6 : 1);
        @(posedge clk);
        bus(1'b1, SMC, 8'h00);
    endtask
    task automatic stop_test();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(port_rst), 32'h0000_0001);
        srcs <= 7'h00;
        release_chk();
        $display("test power_on done");
        rchk(SMC, 8'h00);
        rchk(GATE, 8'h00);
        rchk(BAD, 8'h00);
        chk(32'(resp), 32'h0000_0002);
        bus(1'b1, BAD, 8'h5A);
        chk(32'(resp), 32'h0000_0002);
        bus(1'b1, SMC, 8'hFF);
        chk(32'(resp), 32'h0000_0000);
        rchk(SMC, 8'h0F);
        bus(1'b1, GATE, 8'hFF);
        rchk(GATE, 8'h1F);
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, GATE, 8'(1 << i));
            repeat (2) @(posedge clk);
            chk(32'(gates), 32'(1 << i));
            chk(32'(mux_blk), 32'(i == 0));
        end
        bus(1'b1, GATE, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            wake_dly <= i[0] ? 4'h2 : 4'hC;
            nap(codes[i], 1'b1, 8'h00, 8'h00, i < 5, 1'b0);
        end
        nap(3'h2, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0);
        $display("test sleep_modes done");
        nap(3'h2, 1'b1, 8'h60, 8'h40, 1'b1, 1'b1);
        nap(3'h2, 1'b1, 8'h00, 8'h40, 1'b1, 1'b0);
        nap(3'h2, 1'b1, 8'h20, 8'h40, 1'b1, 1'b0);
        bus(1'b1, SYS, 8'h60);
        bus(1'b1, SYS, 8'h40);
        repeat (10) @(posedge clk);
        bus(1'b0, SYS, 8'h00);
        chk(q & 32'h0000_0040, 32'h0000_0000);
        nap(3'h2, 1'b1, 8'h00, 8'h00, 1'b1, 1'b0);
        $display("test sleep_off done");
        for (int i = 0; i < 7; i++) begin
            bus(1'b1, GATE, 8'h04);
            srcs <= pats[i];
            @(negedge clk);
            if (i == 4) chk(32'(int_rst), 32'h0000_0001);
            repeat (60) @(posedge clk);
            chk(32'(int_rst), 32'(i < 5));
            if (i < 5) chk(32'(port_rst), 32'h0000_0001);
            srcs <= 7'h00;
            if (i < 5) release_chk();
            rchk(GATE, i < 5 ? 8'h00 : 8'h04);
        end
        $display("test reset_sources done");
        stop_test();
    end
    initial begin
        #500_000;
        fails++;
        stop_test();
    end
endmodule // tb
`default_nettype wire
